// file: hw/apb_port.sv
// APB slave front end: one wait state, registered answer, error on unmapped address
// Assumes the register side answers rdata and hit combinationally from idx
`timescale 1ns/1ps
`default_nettype none

module apb_port (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire phy_evt_pkg::apb_addr_t i_paddr,
   input wire phy_evt_pkg::apb_data_t i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output phy_evt_pkg::apb_data_t o_prdata,
   // Register side
   reg_acc_if.port r
);
   import phy_evt_pkg::*;

   port_state_t q;
   port_state_t d;
   logic aligned;
   logic access;

   // Word aligned and inside the index field
   assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
   assign access = i_psel && i_penable && !q.ready;
   assign r.acc = access && aligned;
   assign r.wr = i_pwrite;
   assign r.idx = i_paddr[9:2];
   assign r.wdata = i_pwdata[15:0];

   always_comb begin
      d = q;
      d.ready = access;
      d.err = 1'b0;
      if (access) begin
         d.err = !(aligned && r.hit);
         if (!i_pwrite) begin
            d.rdata = (aligned && r.hit) ? {16'h0000, r.rdata} : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_pready = q.ready;
   assign o_pslverr = q.err;
   assign o_prdata = q.rdata;
endmodule

`default_nettype wire

// file: hw/phy_event_status.sv
// Event status two register, interrupt controls and the two error counters of a 10/100 PHY
// Assumes event inputs are one-cycle pulses synchronous to I_CLK_SYS and an APB master
// Behaviour
// [RQ1] Bit 15 latches energy efficient Ethernet error
// [RQ2] Bit 14 latches auto-negotiation error
// [RQ3] Bit 13 latches page received
// [RQ4] Bit 12 latches loopback FIFO over/underflow
// [RQ5] Bit 11 latches crossover status change
// [RQ6] Bit 10 latches sleep mode event
// [RQ7] Bit 9 latches polarity change or wake packet
// [RQ8] Bit 8 latches jabber detection
// [RQ9] Bits 7:0 enable status bits eight above
// [RQ10] False carrier count in 7:0, upper zero
// [RQ11] False carrier count stops at FFh
// [RQ12] False carrier count above 7Fh raises event
// [RQ13] Reading false carrier count clears it
// [RQ14] Receive error counts symbol errors under carrier
// [RQ15] Receive error count frozen in loopback
// [RQ16] Receive error count stops at FFFFh
// [RQ17] Receive error count above 7Fh raises event
// [RQ18] Reading receive error count clears it
// [RQ19] Half-full events latch status one, gated
// [RQ20] Global enable gates all event interrupts
// [RQ21] Pin driven low on interrupt when output
// [RQ22] Read clears flags unless event repeats
// [RQ23] Request is OR of flag AND enable
`timescale 1ns/1ps
`default_nettype none
`include "phy_evt_defs.svh"

module phy_event_status (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire phy_evt_pkg::apb_addr_t I_PADDR,
   input wire phy_evt_pkg::apb_data_t I_PWDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output phy_evt_pkg::apb_data_t O_PRDATA,
   // Event pulses from the detectors
   input wire logic I_EEE_ERR,
   input wire logic I_AN_ERR,
   input wire logic I_PAGE_RCVD,
   input wire logic I_LB_FIFO_ERR,
   input wire logic I_MDIX_CHG,
   input wire logic I_SLEEP_EVT,
   input wire logic I_POL_CHG,
   input wire logic I_WOL_PKT,
   input wire logic I_JABBER,
   // Receive path
   input wire logic I_FALSE_CARRIER,
   input wire logic I_RX_SYM_ERR,
   input wire logic I_RX_DV,
   input wire logic I_CARRIER_OK,
   input wire logic I_MII_LOOPBACK,
   // Interrupt request and shared interrupt or power-down pin
   output logic O_IRQ,
   output logic O_INT_PIN_O,
   output logic O_INT_PIN_OE_B
);
   import phy_evt_pkg::*;

   localparam top_state_t RST = '{
      ctl: `PE_RST_CTL,
      en1: `PE_RST_BITS2,
      st1: `PE_RST_BITS2,
      st2: `PE_RST_BITS8,
      en2: `PE_RST_BITS8,
      irq: 1'b0,
      pin_o: 1'b1,
      pin_oe_b: 1'b1
   };

   top_state_t q;
   top_state_t d;
   logic [7:0] ev2;
   logic [7:0] st1_n;
   logic rd;
   logic wr;

   reg_acc_if r ();
   evt_cnt_if fc ();
   evt_cnt_if re ();

   // Sticky flags: a set in the clearing cycle wins
   function automatic logic [7:0] latch_bits(input logic [7:0] old, input logic [7:0] set, input logic clr);
      latch_bits = set | (old & ~{8{clr}});
   endfunction

   function automatic logic sel(input logic [7:0] idx, input logic [7:0] want);
      sel = (idx == want);
   endfunction

   apb_port u_port (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .i_psel(I_PSEL),
      .i_penable(I_PENABLE),
      .i_pwrite(I_PWRITE),
      .i_paddr(I_PADDR),
      .i_pwdata(I_PWDATA),
      .o_pready(O_PREADY),
      .o_pslverr(O_PSLVERR),
      .o_prdata(O_PRDATA),
      .r(r.port)
   );

   sat_counter #(
      .MAX(`PE_FC_MAX)
   ) u_fc_cnt (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .c(fc.cnt)
   );

   sat_counter #(
      .MAX(`PE_RE_MAX)
   ) u_re_cnt (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .c(re.cnt)
   );

   // Event sources of status two
   assign ev2[`PE_EV_EEE] = I_EEE_ERR; // [RQ1]
   assign ev2[`PE_EV_AN_ERR] = I_AN_ERR; // [RQ2]
   assign ev2[`PE_EV_PAGE] = I_PAGE_RCVD; // [RQ3]
   assign ev2[`PE_EV_LB_FIFO] = I_LB_FIFO_ERR; // [RQ4]
   assign ev2[`PE_EV_MDIX] = I_MDIX_CHG; // [RQ5]
   assign ev2[`PE_EV_SLEEP] = I_SLEEP_EVT; // [RQ6]
   assign ev2[`PE_EV_POL_WOL] = I_POL_CHG || I_WOL_PKT; // [RQ7]
   assign ev2[`PE_EV_JABBER] = I_JABBER; // [RQ8]

   // Register access strobes
   assign r.hit = (r.idx >= `PE_IDX_CTL) && (r.idx <= `PE_IDX_REC);
   assign rd = r.acc && r.hit && !r.wr;
   assign wr = r.acc && r.hit && r.wr;

   // Counter drive
   assign fc.inc = I_FALSE_CARRIER;
   assign fc.hold = 1'b0;
   assign fc.clr = rd && sel(r.idx, `PE_IDX_FCC); // [RQ13]
   assign re.inc = I_RX_SYM_ERR && I_RX_DV && I_CARRIER_OK; // [RQ14]
   assign re.hold = I_MII_LOOPBACK; // [RQ15]
   assign re.clr = rd && sel(r.idx, `PE_IDX_REC); // [RQ18]

   // Read data
   always_comb begin
      case (r.idx)
         `PE_IDX_CTL: begin
            r.rdata = {13'h0000, q.ctl};
         end
         `PE_IDX_ST1: begin
            r.rdata = {6'h00, q.st1, 6'h00, q.en1};
         end
         `PE_IDX_ST2: begin
            r.rdata = {q.st2, q.en2};
         end
         `PE_IDX_FCC: begin
            r.rdata = {8'h00, fc.count[`PE_FC_MSB:0]}; // [RQ10]
         end
         `PE_IDX_REC: begin
            r.rdata = re.count;
         end
         default: begin
            r.rdata = 16'h0000;
         end
      endcase
   end

   // Next state
   always_comb begin
      d = q;
      st1_n = latch_bits({6'h00, q.st1}, {6'h00, fc.half, re.half}, rd && sel(r.idx, `PE_IDX_ST1)); // [RQ19]
      if (wr && sel(r.idx, `PE_IDX_CTL)) begin
         d.ctl = r.wdata[`PE_CTL_W-1:0];
      end
      if (wr && sel(r.idx, `PE_IDX_ST1)) begin
         d.en1 = r.wdata[`PE_EN1_LSB+1:`PE_EN1_LSB]; // [RQ19]
      end
      if (wr && sel(r.idx, `PE_IDX_ST2)) begin
         d.en2 = r.wdata[`PE_EN2_LSB+7:`PE_EN2_LSB]; // [RQ9]
      end
      // Flags ignore writes; a read clears them unless the event repeats
      d.st2 = latch_bits(q.st2, ev2, rd && sel(r.idx, `PE_IDX_ST2)); // [RQ22]
      d.st1 = st1_n[1:0];
      // Test bit forces a request regardless of flags
      d.irq = (d.ctl[`PE_CTL_GLOBAL_EN] && ((|(d.st2 & d.en2)) || (|(d.st1 & d.en1)))) // [RQ20] [RQ23]
         || d.ctl[`PE_CTL_TEST];
      d.pin_oe_b = !d.ctl[`PE_CTL_PIN_OUT];
      d.pin_o = !(d.irq && d.ctl[`PE_CTL_PIN_OUT]); // [RQ21]
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign O_IRQ = q.irq;
   assign O_INT_PIN_O = q.pin_o;
   assign O_INT_PIN_OE_B = q.pin_oe_b;

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_B);

   a_eee_flag_set: assert property (I_EEE_ERR |=> q.st2[`PE_EV_EEE]) // [RQ1]
      else $error("EEE error not latched");
   a_an_err_set: assert property (I_AN_ERR |=> q.st2[`PE_EV_AN_ERR]) // [RQ2]
      else $error("auto-negotiation error not latched");
   a_page_flag_set: assert property (I_PAGE_RCVD |=> q.st2[`PE_EV_PAGE]) // [RQ3]
      else $error("page received not latched");
   a_fifo_flag_set: assert property (I_LB_FIFO_ERR |=> q.st2[`PE_EV_LB_FIFO]) // [RQ4]
      else $error("loopback FIFO error not latched");
   a_mdix_flag_set: assert property (I_MDIX_CHG |=> q.st2[`PE_EV_MDIX]) // [RQ5]
      else $error("crossover change not latched");
   a_sleep_flag_set: assert property (I_SLEEP_EVT |=> q.st2[`PE_EV_SLEEP]) // [RQ6]
      else $error("sleep event not latched");
   a_pol_wol_set: assert property ((I_POL_CHG || I_WOL_PKT) |=> q.st2[`PE_EV_POL_WOL]) // [RQ7]
      else $error("polarity or wake packet not latched");
   a_jabber_set: assert property (I_JABBER |=> q.st2[`PE_EV_JABBER]) // [RQ8]
      else $error("jabber not latched");
   a_enable_write: assert property (wr && r.idx == `PE_IDX_ST2 |=> q.en2 == $past(r.wdata[7:0])) // [RQ9]
      else $error("status two enables not written");
   a_fc_upper_zero: assert property (r.idx == `PE_IDX_FCC |-> r.rdata[15:8] == 8'h00) // [RQ10]
      else $error("false carrier reserved bits not zero");
   a_fc_read_clear: assert property (fc.clr && !fc.inc |=> fc.count == 16'h0000) // [RQ13]
      else $error("false carrier count not cleared by read");
   a_fc_below_max: assert property (fc.count <= `PE_FC_MAX) // [RQ11]
      else $error("false carrier count above its maximum");
   a_rx_err_count: assert property (re.inc && !re.hold && !re.clr && re.count != `PE_RE_MAX
         |=> re.count == $past(re.count) + 16'h0001) // [RQ14]
      else $error("receive error not counted");
   a_rx_no_count: assert property (!re.inc && !re.clr |=> $stable(re.count)) // [RQ14]
      else $error("receive error count moved without an error");
   a_loopback_hold: assert property (re.hold && !re.clr |=> $stable(re.count)) // [RQ15]
      else $error("receive error counted in loopback");
   a_re_read_clear: assert property (re.clr && !re.inc |=> re.count == 16'h0000) // [RQ18]
      else $error("receive error count not cleared by read");
   a_fc_half_latch: assert property (fc.half |=> q.st1[1]) // [RQ12]
      else $error("false carrier half-full not latched");
   a_re_half_latch: assert property (re.half |=> q.st1[0]) // [RQ17]
      else $error("receive error half-full not latched");
   a_st1_read_clear: assert property (rd && r.idx == `PE_IDX_ST1 && !fc.half && !re.half
         |=> q.st1 == 2'h0) // [RQ19]
      else $error("status one not cleared by read");
   a_global_gate: assert property (!q.ctl[`PE_CTL_GLOBAL_EN] && !q.ctl[`PE_CTL_TEST] |-> !q.irq) // [RQ20]
      else $error("interrupt without global enable");
   a_pin_low_on_irq: assert property (q.ctl[`PE_CTL_PIN_OUT] && q.irq |-> !O_INT_PIN_O && !O_INT_PIN_OE_B) // [RQ21]
      else $error("interrupt pin not driven low");
   a_pin_released: assert property (!q.ctl[`PE_CTL_PIN_OUT] |-> O_INT_PIN_OE_B && O_INT_PIN_O) // [RQ21]
      else $error("pin driven while a power-down input");
   a_st2_read_clear: assert property (rd && r.idx == `PE_IDX_ST2 && ev2 == 8'h00 |=> q.st2 == 8'h00) // [RQ22]
      else $error("status two not cleared by read");
   a_st2_sticky: assert property (!(rd && r.idx == `PE_IDX_ST2) |=> (q.st2 & $past(q.st2)) == $past(q.st2)) // [RQ22]
      else $error("status two flag lost without a read");
   a_irq_is_or: assert property (q.ctl[`PE_CTL_GLOBAL_EN] && !q.ctl[`PE_CTL_TEST]
         |-> q.irq == ((|(q.st2 & q.en2)) || (|(q.st1 & q.en1)))) // [RQ23]
      else $error("request is not the OR of enabled flags");
   a_irq_follows: assert property (I_JABBER && q.en2[`PE_EV_JABBER] && q.ctl[`PE_CTL_GLOBAL_EN]
         && !(wr && r.idx == `PE_IDX_ST2) && !(wr && r.idx == `PE_IDX_CTL) |=> q.irq) // [RQ23]
      else $error("enabled event did not raise the request");
endmodule

`default_nettype wire

// file: hw/phy_evt_defs.svh
// Register indices, field positions, limits and reset values of the PHY event status block
// Included by the package and the design files; holds definitions only
`ifndef PHY_EVT_DEFS_SVH
`define PHY_EVT_DEFS_SVH

// Register indices; the APB byte address is four times the index
`define PE_IDX_CTL 8'h11
`define PE_IDX_ST1 8'h12
`define PE_IDX_ST2 8'h13
`define PE_IDX_FCC 8'h14
`define PE_IDX_REC 8'h15

// Control register fields
`define PE_CTL_W 3
`define PE_CTL_PIN_OUT 0
`define PE_CTL_GLOBAL_EN 1
`define PE_CTL_TEST 2

// Status one: half-full flags in bits 9:8, enables in bits 1:0
`define PE_ST1_LSB 8
`define PE_EN1_LSB 0

// Status two: flags in bits 15:8, enables in bits 7:0; event order inside a byte
`define PE_ST2_LSB 8
`define PE_EN2_LSB 0
`define PE_EV_EEE 7
`define PE_EV_AN_ERR 6
`define PE_EV_PAGE 5
`define PE_EV_LB_FIFO 4
`define PE_EV_MDIX 3
`define PE_EV_SLEEP 2
`define PE_EV_POL_WOL 1
`define PE_EV_JABBER 0

// Counters
`define PE_FC_MSB 7
`define PE_FC_MAX 16'h00ff
`define PE_RE_MAX 16'hffff
`define PE_HALF_FULL 16'h007f

// Reset values
`define PE_RST_CTL 3'h0
`define PE_RST_BITS2 2'h0
`define PE_RST_BITS8 8'h00
`define PE_RST_CNT 16'h0000

`endif

// file: hw/phy_evt_if.sv
// Carriers between the top module and its register port and counters
// Assumes one clock domain; no clocking blocks
`timescale 1ns/1ps
`default_nettype none

interface reg_acc_if;
   logic acc;
   logic wr;
   logic [7:0] idx;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic hit;
   modport port (output acc, wr, idx, wdata, input rdata, hit);
   modport regs (input acc, wr, idx, wdata, output rdata, hit);
endinterface

interface evt_cnt_if;
   logic inc;
   logic hold;
   logic clr;
   logic [15:0] count;
   logic half;
   modport cnt (input inc, hold, clr, output count, half);
   modport user (output inc, hold, clr, input count, half);
endinterface

`default_nettype wire

// file: hw/phy_evt_pkg.sv
// Types shared by the PHY event status block
// Assumes the constants header sits beside it
`include "phy_evt_defs.svh"

package phy_evt_pkg;
   typedef logic [11:0] apb_addr_t;
   typedef logic [31:0] apb_data_t;

   typedef struct packed {
      logic [`PE_CTL_W-1:0] ctl;
      logic [1:0] en1;
      logic [1:0] st1;
      logic [7:0] st2;
      logic [7:0] en2;
      logic irq;
      logic pin_o;
      logic pin_oe_b;
   } top_state_t;

   typedef struct packed {
      logic ready;
      logic err;
      apb_data_t rdata;
   } port_state_t;

   typedef struct packed {
      logic [15:0] count;
      logic half;
   } cnt_state_t;
endpackage

// file: hw/sat_counter.sv
// Saturating event counter with clear on read and a half-full crossing pulse
// Assumes clr is a one-cycle pulse taken at the edge that captures read data
`timescale 1ns/1ps
`default_nettype none
`include "phy_evt_defs.svh"

module sat_counter #(
   parameter logic [15:0] MAX = `PE_RE_MAX
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Counter port
   evt_cnt_if.cnt c
);
   import phy_evt_pkg::*;

   cnt_state_t q;
   cnt_state_t d;
   logic step;

   assign step = c.inc && !c.hold; // [RQ15]

   always_comb begin
      d = q;
      if (c.clr) begin
         // An event in the read cycle counts into the fresh value
         d.count = step ? 16'h0001 : 16'h0000; // [RQ13] [RQ18]
      end else if (step && (q.count != MAX)) begin // [RQ11] [RQ16]
         d.count = q.count + 16'h0001;
      end
      d.half = (d.count > `PE_HALF_FULL) && (q.count <= `PE_HALF_FULL); // [RQ12] [RQ17]
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign c.count = q.count;
   assign c.half = q.half;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   a_count_stays_max: assert property (q.count == MAX && !c.clr |=> q.count == MAX) // [RQ11]
      else $error("counter left its maximum without a read");
   a_count_clears: assert property (c.clr |=> q.count <= 16'h0001) // [RQ13]
      else $error("read did not clear the counter");
   a_hold_freezes: assert property (c.hold && !c.clr |=> $stable(q.count)) // [RQ15]
      else $error("counter moved while held");
   a_half_crossing: assert property (q.half |-> q.count > `PE_HALF_FULL && $past(q.count) <= `PE_HALF_FULL) // [RQ12]
      else $error("half-full pulse without a crossing");
   a_step_counts: assert property (step && !c.clr && q.count < MAX |=> q.count == $past(q.count) + 16'h0001) // [RQ16]
      else $error("counter missed an event");
endmodule

`default_nettype wire

// file: sim/apb_host.sv
// Station management host model: APB master with one bounded transfer task
// Assumes a single rising-edge clock shared with the register block
`timescale 1ns/1ps
`default_nettype none

module apb_host (
   // Clock
   input wire logic i_clk,
   // APB master
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output phy_evt_pkg::apb_addr_t o_paddr,
   output phy_evt_pkg::apb_data_t o_pwdata,
   input wire logic i_pready,
   input wire logic i_pslverr,
   input wire phy_evt_pkg::apb_data_t i_prdata
);
   import phy_evt_pkg::*;

   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 12'h000;
      o_pwdata = 32'h00000000;
   end

   // Request held until pready is seen high; to is set if it never comes
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                       output logic [15:0] rd, output logic err, output logic to);
      int n;
      n = 0;
      to = 1'b1;
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_pwrite <= wr;
      o_paddr <= {2'b00, idx, 2'b00};
      o_pwdata <= {16'h0000, wd};
      @(posedge i_clk);
      o_penable <= 1'b1;
      while (to && n < 20) begin
         @(posedge i_clk);
         n++;
         if (i_pready === 1'b1) begin
            to = 1'b0;
         end
      end
      rd = i_prdata[15:0];
      err = i_pslverr;
      // Released address and data lines no longer show the last value
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_paddr <= ~o_paddr;
      o_pwdata <= ~o_pwdata;
   endtask
endmodule

`default_nettype wire

// file: sim/phy_event_status_tb.sv
// Self-checking bench for the PHY event status block
// Assumes the host model drives APB; events and receive inputs come from here
`timescale 1ns/1ps
`default_nettype none
`include "phy_evt_defs.svh"

module phy_event_status_tb;
   import phy_evt_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel;
   logic penable;
   logic pwrite;
   logic pready;
   logic pslverr;
   logic irq;
   logic pin_o;
   logic pin_oe_b;
   apb_addr_t paddr;
   apb_data_t pwdata;
   apb_data_t prdata;
   logic [8:0] ev = 9'h000;
   // False carrier, symbol error, data valid, carrier ok, loopback
   logic [4:0] rx = 5'h00;
   int mismatches = 0;
   int n_tests = 0;
   logic [15:0] rdv;
   logic err;
   logic to;
   // Event pulse beside the status two flag it should set
   logic [16:0] rows [9] = '{17'h10080, 17'h08040, 17'h04020, 17'h02010, 17'h01008,
                            17'h00804, 17'h00402, 17'h00202, 17'h00101};

   always #4 clk = ~clk;

   apb_host host (.i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
      .o_paddr(paddr), .o_pwdata(pwdata), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata));

   phy_event_status DUT (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .O_PRDATA(prdata), .I_EEE_ERR(ev[8]), .I_AN_ERR(ev[7]), .I_PAGE_RCVD(ev[6]), .I_LB_FIFO_ERR(ev[5]),
      .I_MDIX_CHG(ev[4]), .I_SLEEP_EVT(ev[3]), .I_POL_CHG(ev[2]), .I_WOL_PKT(ev[1]), .I_JABBER(ev[0]),
      .I_FALSE_CARRIER(rx[4]), .I_RX_SYM_ERR(rx[3]), .I_RX_DV(rx[2]), .I_CARRIER_OK(rx[1]),
      .I_MII_LOOPBACK(rx[0]), .O_IRQ(irq), .O_INT_PIN_O(pin_o), .O_INT_PIN_OE_B(pin_oe_b));

   task summarize;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   task chkb(input string n, input logic e, input logic s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", n, e, s);
      end
   endtask

   task acc(input logic w, input logic [7:0] idx, input logic [15:0] wd);
      host.xfer(w, idx, wd, rdv, err, to);
      if (to) begin
         mismatches++;
         $display("wrong value pready expected 1 seen 0");
         summarize();
      end
   endtask

   task rd(input logic [7:0] idx, input logic [15:0] e, input string n);
      acc(1'b0, idx, 16'h0000);
      chk(n, e, rdv);
      chk("read data upper half", 16'h0000, prdata[31:16]);
      chkb("slave error", 1'b0, err);
   endtask

   task pulse(input logic [8:0] p);
      @(posedge clk);
      ev <= p;
      @(posedge clk);
      ev <= 9'h000;
      @(negedge clk);
   endtask

   // Drives rx for n edges, then lets the half-full flag settle
   task burst(input logic [4:0] v, input int n);
      @(posedge clk);
      rx <= v;
      repeat (n) @(posedge clk);
      rx <= 5'h00;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chkb("irq", 1'b0, irq);
      chkb("pin enable", 1'b1, pin_oe_b);
      for (int i = 8'h11; i <= 8'h15; i++) rd(i[7:0], 16'h0000, "reset value");
      $display("test reset done");
      acc(1'b1, `PE_IDX_CTL, 16'h0003);
      acc(1'b1, `PE_IDX_ST2, 16'h00ff);
      for (int r = 0; r < 9; r++) begin
         pulse(rows[r][16:8]);
         chkb("irq", 1'b1, irq);
         chkb("pin", 1'b0, pin_o);
         chkb("pin enable on", 1'b0, pin_oe_b);
         rd(`PE_IDX_ST2, {rows[r][7:0], 8'hff}, "status two");
         rd(`PE_IDX_ST2, 16'h00ff, "status two cleared");
         chkb("irq after read", 1'b0, irq);
      end
      $display("test event table done");
      acc(1'b1, `PE_IDX_ST2, 16'h00fe);
      pulse(9'h001);
      chkb("masked irq", 1'b0, irq);
      rd(`PE_IDX_ST2, 16'h01fe, "masked flag");
      acc(1'b1, `PE_IDX_CTL, 16'h0001);
      pulse(9'h100);
      chkb("global off irq", 1'b0, irq);
      chkb("idle pin", 1'b1, pin_o);
      acc(1'b1, `PE_IDX_CTL, 16'h0004);
      @(negedge clk);
      chkb("pin released", 1'b1, pin_oe_b);
      chkb("test irq", 1'b1, irq);
      rd(`PE_IDX_CTL, 16'h0004, "control");
      rd(`PE_IDX_ST2, 16'h80fe, "flag under global off");
      acc(1'b1, `PE_IDX_FCC, 16'hffff);
      rd(`PE_IDX_FCC, 16'h0000, "read-only count");
      acc(1'b1, 8'h16, 16'h0000);
      chkb("unmapped error", 1'b1, err);
      $display("test controls done");
      acc(1'b1, `PE_IDX_CTL, 16'h0003);
      acc(1'b1, `PE_IDX_ST1, 16'h0003);
      burst(5'h10, 127);
      chkb("no half-full irq", 1'b0, irq);
      rd(`PE_IDX_ST1, 16'h0003, "status one at 7f");
      burst(5'h10, 1);
      chkb("half-full irq", 1'b1, irq);
      rd(`PE_IDX_ST1, 16'h0203, "false carrier half-full");
      burst(5'h10, 200);
      rd(`PE_IDX_FCC, 16'h00ff, "false carrier saturated");
      rd(`PE_IDX_FCC, 16'h0000, "false carrier cleared");
      $display("test false carrier done");
      burst(5'h0f, 10);
      burst(5'h0c, 10);
      burst(5'h0a, 10);
      rd(`PE_IDX_REC, 16'h0000, "gated receive errors");
      burst(5'h0e, 128);
      rd(`PE_IDX_REC, 16'h0080, "receive error count");
      rd(`PE_IDX_ST1, 16'h0103, "receive error half-full");
      burst(5'h0e, 65540);
      rd(`PE_IDX_REC, 16'hffff, "receive error saturated");
      rd(`PE_IDX_REC, 16'h0000, "receive error cleared");
      $display("test receive errors done");
      // Mid-run reset with a flag pending and the pin driven
      chkb("irq before reset", 1'b1, irq);
      chkb("pin enable before reset", 1'b0, pin_oe_b);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chkb("irq after reset", 1'b0, irq);
      chkb("pin enable after reset", 1'b1, pin_oe_b);
      chkb("pin after reset", 1'b1, pin_o);
      rd(`PE_IDX_CTL, 16'h0000, "control after reset");
      rd(`PE_IDX_ST1, 16'h0000, "status one after reset");
      rd(`PE_IDX_ST2, 16'h0000, "status two after reset");
      $display("test mid-run reset done");
      summarize();
   end
endmodule

`default_nettype wire
